// >>> shared/fldr_pkg.sv
/*
 Constants for the flash LED driver control-register bank: register offsets,
 field positions, power-on values, mode encodings and safety-timer durations.
 Assumes a 250 MHz system clock and an I2C-compatible serial host.
*/
package fldr_pkg;

    localparam logic [6:0] SLAVE_ADDR         = 7'h53;

    localparam logic [7:0] OFS_GENERAL        = 8'h10;
    localparam logic [7:0] OFS_MF_OPTIONS     = 8'h20;
    localparam logic [7:0] OFS_STEP_TIME      = 8'h50;
    localparam logic [7:0] OFS_TORCH          = 8'hA0;
    localparam logic [7:0] OFS_FLASH          = 8'hB0;
    localparam logic [7:0] OFS_SAFETY         = 8'hC0;

    localparam logic [7:0] RST_GENERAL        = 8'h18;
    localparam logic [7:0] RST_MF_OPTIONS     = 8'hE0;
    localparam logic [7:0] RST_STEP_TIME      = 8'hFC;
    localparam logic [7:0] RST_TORCH          = 8'h80;
    localparam logic [7:0] RST_FLASH          = 8'h80;
    localparam logic [7:0] RST_SAFETY         = 8'hF0;

    // Bits that are writable in each register; the rest read as their fixed value
    localparam logic [7:0] WMASK_GENERAL      = 8'h27;
    localparam logic [7:0] WMASK_MF_OPTIONS   = 8'h1F;
    localparam logic [7:0] WMASK_STEP_TIME    = 8'h03;
    localparam logic [7:0] WMASK_TORCH        = 8'h1F;
    localparam logic [7:0] WMASK_FLASH        = 8'h7F;
    localparam logic [7:0] WMASK_SAFETY       = 8'h0F;

    localparam int         POS_MODE_LOW       = 0;
    localparam int         POS_MODE_HIGH      = 1;
    localparam int         POS_VOLT_OUT       = 2;
    localparam int         POS_FEEDBACK       = 5;
    localparam int         POS_OVERVOLT       = 3;
    localparam int         POS_IND_LIMIT      = 4;

    typedef enum logic [1:0] {
        MODE_SHUTDOWN  = 2'b00,
        MODE_INDICATOR = 2'b01,
        MODE_TORCH     = 2'b10,
        MODE_FLASH     = 2'b11
    } fldr_mode_t;

    localparam int         CLK_MHZ            = 250;
    localparam int         DUR_SHORT_MS       = 50;
    localparam int         DUR_STEP_MS        = 100;
    localparam int         DUR_LONG_MS        = 3200;
    localparam int         CYC_PER_MS         = CLK_MHZ * 1000;
    localparam logic [3:0] CODE_SHORT         = 4'h0;
    localparam logic [3:0] CODE_LONG          = 4'hF;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_ADDR    = 3'b001,
        ST_ACK     = 3'b010,
        ST_DATA_RX = 3'b011,
        ST_DATA_TX = 3'b100,
        ST_RD_ACK  = 3'b101
    } fldr_state_t;

endpackage

// >>> hw/fldr_sync.sv
/*
 Two-flop synchroniser for one asynchronous pin.
 Assumes the input is a level from outside the i_mclk domain.
*/
`timescale 1ns/10ps
module fldr_sync
(
    input  wire logic i_mclk,
    input  wire logic i_rst_b,
    input  wire logic i_async,
    output logic      o_sync
);
    logic meta_reg;
    logic meta_next;
    logic sync_next;

    always_comb
    begin
        meta_next = i_async;
        sync_next = meta_reg;
    end

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            meta_reg <= 1'b1;
            o_sync   <= 1'b1;
        end
        else
        begin
            meta_reg <= meta_next;
            o_sync   <= sync_next;
        end
    end
endmodule

// >>> hw/fldr_regs.sv
/*
 Control-register bank of a dual flash LED driver behind an I2C-compatible
 slave. Holds mode, brightness, option and safety-duration settings and
 decodes them for the analog side. Assumes SCL and SDA arrive as pins,
 sampled on i_mclk, and that SDA is open drain (enable high pulls low).
*/
// Functional notes
// RULE1: Safety duration code in 0xC0 bits 3:0
// RULE2: Code 0 50ms, 1-14 times 100ms, 15 3200ms
// RULE3: Mode 00 off, 01 indicator, 10 torch, 11 flash
// RULE4: Torch brightness code 0..31 applied to torch
// RULE5: Flash brightness code 0..127 applied to flash
// RULE6: Feedback bit clear 450mV, set 350mV
// RULE7: Inductor limit bit clear 2.5A, set 1.7A
// RULE8: Overvoltage bit clear 5.6V, set 18.9V
// RULE9: Voltage output bit set enables 4.98V regulation
// RULE10: Settings held until next register write
// RULE11: Host controls device only by serial writes
// RULE12: Slave address 0x53, registers readable and writable
// RULE13: Voltage mode keeps mode bits, sinks follow them
// RULE14: Register 0x10: mode 1:0, volt 2, feedback 5
// RULE15: Safety register bits 7:4 read as ones
// RULE16: Writes to unmapped addresses change nothing
`timescale 1ns/10ps
module fldr_regs
    import fldr_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_rst_b,
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    output logic             o_sda_oe,
    output fldr_pkg::fldr_mode_t o_mode,
    output logic             o_sinks_on,
    output logic             o_volt_out_en,
    output logic             o_fb_350mv,
    output logic             o_ilim_1p7a,
    output logic             o_ovp_high,
    output logic [4:0]       o_torch_code,
    output logic [6:0]       o_flash_code,
    output logic [3:0]       o_safety_code,
    output logic [31:0]      o_safety_cycles
);
    logic        scl_s;
    logic        sda_s;
    logic        scl_d_reg;
    logic        sda_d_reg;
    fldr_state_t state_reg;
    fldr_state_t state_next;
    logic [3:0]  bit_cnt_reg;
    logic [3:0]  bit_cnt_next;
    logic [7:0]  shift_reg;
    logic [7:0]  shift_next;
    logic [7:0]  ptr_reg;
    logic [7:0]  ptr_next;
    logic        have_ptr_reg;
    logic        have_ptr_next;
    logic        is_read_reg;
    logic        is_read_next;
    logic        sda_oe_next;
    logic [7:0]  gen_reg;
    logic [7:0]  gen_next;
    logic [7:0]  mf_reg;
    logic [7:0]  mf_next;
    logic [7:0]  step_reg;
    logic [7:0]  step_next;
    logic [7:0]  torch_reg;
    logic [7:0]  torch_next;
    logic [7:0]  flash_reg;
    logic [7:0]  flash_next;
    logic [7:0]  safety_reg;
    logic [7:0]  safety_next;
    logic [31:0] cycles_next;
    logic [7:0]  rd_data;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_cond;
    logic        stop_cond;
    logic        wr_strobe;

    fldr_sync u_sync_scl
    (
        .i_mclk  (i_mclk),
        .i_rst_b (i_rst_b),
        .i_async (i_scl),
        .o_sync  (scl_s)
    );

    fldr_sync u_sync_sda
    (
        .i_mclk  (i_mclk),
        .i_rst_b (i_rst_b),
        .i_async (i_sda),
        .o_sync  (sda_s)
    );

    assign scl_rise   = scl_s & ~scl_d_reg;
    assign scl_fall   = ~scl_s & scl_d_reg;
    assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_cond  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    // Read-back data; fixed bits come from the power-on value
    always_comb
    begin
        case (ptr_reg)
            OFS_GENERAL:    rd_data = gen_reg;
            OFS_MF_OPTIONS: rd_data = mf_reg;
            OFS_STEP_TIME:  rd_data = step_reg;
            OFS_TORCH:      rd_data = torch_reg;
            OFS_FLASH:      rd_data = flash_reg;
            OFS_SAFETY:     rd_data = safety_reg; // RULE15
            default:        rd_data = 8'h00;
        endcase
    end

    // Serial slave protocol
    always_comb
    begin
        state_next    = state_reg;
        bit_cnt_next  = bit_cnt_reg;
        shift_next    = shift_reg;
        ptr_next      = ptr_reg;
        have_ptr_next = have_ptr_reg;
        is_read_next  = is_read_reg;
        sda_oe_next   = o_sda_oe;
        wr_strobe     = 1'b0;
        if (start_cond)
        begin
            state_next    = ST_ADDR;
            bit_cnt_next  = 4'h0;
            have_ptr_next = 1'b0;
            sda_oe_next   = 1'b0;
        end
        else if (stop_cond)
        begin
            state_next  = ST_IDLE;
            sda_oe_next = 1'b0;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    sda_oe_next = 1'b0;
                end
                ST_ADDR, ST_DATA_RX:
                begin
                    if (scl_rise)
                    begin
                        shift_next   = {shift_reg[6:0], sda_s};
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end
                    else if (scl_fall && bit_cnt_reg == 4'h8)
                    begin
                        bit_cnt_next = 4'h0;
                        if (state_reg == ST_ADDR)
                        begin
                            if (shift_reg[7:1] == SLAVE_ADDR) // RULE12
                            begin
                                is_read_next = shift_reg[0];
                                sda_oe_next  = 1'b1;
                                state_next   = ST_ACK;
                            end
                            else
                            begin
                                state_next = ST_IDLE;
                            end
                        end
                        else
                        begin
                            sda_oe_next = 1'b1;
                            state_next  = ST_ACK;
                            if (!have_ptr_reg)
                            begin
                                ptr_next      = shift_reg;
                                have_ptr_next = 1'b1;
                            end
                            else
                            begin
                                wr_strobe = 1'b1; // RULE11
                            end
                        end
                    end
                end
                ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (is_read_reg)
                        begin
                            shift_next   = rd_data;
                            sda_oe_next  = ~rd_data[7];
                            bit_cnt_next = 4'h1;
                            state_next   = ST_DATA_TX;
                        end
                        else
                        begin
                            sda_oe_next = 1'b0;
                            state_next  = ST_DATA_RX;
                        end
                    end
                end
                ST_DATA_TX:
                begin
                    if (scl_fall)
                    begin
                        if (bit_cnt_reg == 4'h8)
                        begin
                            sda_oe_next = 1'b0;
                            state_next  = ST_RD_ACK;
                        end
                        else
                        begin
                            shift_next   = {shift_reg[6:0], 1'b0};
                            sda_oe_next  = ~shift_reg[6];
                            bit_cnt_next = bit_cnt_reg + 4'h1;
                        end
                    end
                end
                ST_RD_ACK:
                begin
                    if (scl_rise)
                    begin
                        state_next = sda_s ? ST_IDLE : ST_ACK;
                    end
                end
                default:
                begin
                    state_next  = ST_IDLE;
                    sda_oe_next = 1'b0;
                end
            endcase
        end
    end

    // Register writes; only an addressed write changes state
    always_comb
    begin
        gen_next    = gen_reg;
        mf_next     = mf_reg;
        step_next   = step_reg;
        torch_next  = torch_reg;
        flash_next  = flash_reg;
        safety_next = safety_reg;
        if (wr_strobe) // RULE10
        begin
            case (ptr_reg)
                OFS_GENERAL:    gen_next = (shift_reg & WMASK_GENERAL)
                                           | (RST_GENERAL & ~WMASK_GENERAL); // RULE14
                OFS_MF_OPTIONS: mf_next = (shift_reg & WMASK_MF_OPTIONS)
                                          | (RST_MF_OPTIONS & ~WMASK_MF_OPTIONS);
                OFS_STEP_TIME:  step_next = (shift_reg & WMASK_STEP_TIME)
                                            | (RST_STEP_TIME & ~WMASK_STEP_TIME);
                OFS_TORCH:      torch_next = (shift_reg & WMASK_TORCH)
                                             | (RST_TORCH & ~WMASK_TORCH); // RULE4
                OFS_FLASH:      flash_next = (shift_reg & WMASK_FLASH)
                                             | (RST_FLASH & ~WMASK_FLASH); // RULE5
                OFS_SAFETY:     safety_next = (shift_reg & WMASK_SAFETY)
                                              | (RST_SAFETY & ~WMASK_SAFETY); // RULE1 RULE15
                default:        ; // RULE16
            endcase
        end
    end

    // Safety-timer decode into clock cycles
    always_comb
    begin
        if (safety_reg[3:0] == CODE_SHORT)
        begin
            cycles_next = 32'(DUR_SHORT_MS * CYC_PER_MS); // RULE2
        end
        else if (safety_reg[3:0] == CODE_LONG)
        begin
            cycles_next = 32'(DUR_LONG_MS * CYC_PER_MS); // RULE2
        end
        else
        begin
            cycles_next = 32'(safety_reg[3:0]) * 32'(DUR_STEP_MS * CYC_PER_MS); // RULE2
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            scl_d_reg       <= 1'b1;
            sda_d_reg       <= 1'b1;
            state_reg       <= ST_IDLE;
            bit_cnt_reg     <= 4'h0;
            shift_reg       <= 8'h00;
            ptr_reg         <= 8'h00;
            have_ptr_reg    <= 1'b0;
            is_read_reg     <= 1'b0;
            o_sda_oe        <= 1'b0;
            gen_reg         <= RST_GENERAL;
            mf_reg          <= RST_MF_OPTIONS;
            step_reg        <= RST_STEP_TIME;
            torch_reg       <= RST_TORCH;
            flash_reg       <= RST_FLASH;
            safety_reg      <= RST_SAFETY;
            o_mode          <= MODE_SHUTDOWN;
            o_sinks_on      <= 1'b0;
            o_volt_out_en   <= 1'b0;
            o_fb_350mv      <= 1'b0;
            o_ilim_1p7a     <= 1'b0;
            o_ovp_high      <= 1'b0;
            o_torch_code    <= 5'h00;
            o_flash_code    <= 7'h00;
            o_safety_code   <= 4'h0;
            o_safety_cycles <= 32'(DUR_SHORT_MS * CYC_PER_MS);
        end
        else
        begin
            scl_d_reg       <= scl_s;
            sda_d_reg       <= sda_s;
            state_reg       <= state_next;
            bit_cnt_reg     <= bit_cnt_next;
            shift_reg       <= shift_next;
            ptr_reg         <= ptr_next;
            have_ptr_reg    <= have_ptr_next;
            is_read_reg     <= is_read_next;
            o_sda_oe        <= sda_oe_next;
            gen_reg         <= gen_next;
            mf_reg          <= mf_next;
            step_reg        <= step_next;
            torch_reg       <= torch_next;
            flash_reg       <= flash_next;
            safety_reg      <= safety_next;
            o_mode          <= fldr_mode_t'(gen_reg[POS_MODE_HIGH:POS_MODE_LOW]); // RULE3
            o_sinks_on      <= gen_reg[POS_MODE_HIGH] | gen_reg[POS_MODE_LOW]; // RULE13
            o_volt_out_en   <= gen_reg[POS_VOLT_OUT]; // RULE9
            o_fb_350mv      <= gen_reg[POS_FEEDBACK]; // RULE6
            o_ilim_1p7a     <= mf_reg[POS_IND_LIMIT]; // RULE7
            o_ovp_high      <= mf_reg[POS_OVERVOLT]; // RULE8
            o_torch_code    <= torch_reg[4:0]; // RULE4
            o_flash_code    <= flash_reg[6:0]; // RULE5
            o_safety_code   <= safety_reg[3:0]; // RULE1
            o_safety_cycles <= cycles_next;
        end
    end
endmodule

// >>> verif/fldr_regs_monitor.sv
/*
 Checker for the flash LED register bank, watching only its top-level ports.
 Assumes a single i_mclk domain and the bus host model of this bench.
*/
`timescale 1ns/10ps
module fldr_regs_monitor
    import fldr_pkg::*;
(
    input  wire logic                 i_mclk,
    input  wire logic                 i_rst_b,
    input  wire logic                 i_scl,
    input  wire logic                 i_sda,
    input  wire logic                 o_sda_oe,
    input  wire logic [1:0]           o_mode,
    input  wire logic                 o_sinks_on,
    input  wire logic                 o_volt_out_en,
    input  wire logic                 o_fb_350mv,
    input  wire logic                 o_ilim_1p7a,
    input  wire logic                 o_ovp_high,
    input  wire logic [4:0]           o_torch_code,
    input  wire logic [6:0]           o_flash_code,
    input  wire logic [3:0]           o_safety_code,
    input  wire logic [31:0]          o_safety_cycles
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_b);

    mode_sinks_a: assert property (o_sinks_on == (o_mode != MODE_SHUTDOWN))
        else $error("sink enable does not follow mode");
    safety_short_a: assert property (o_safety_code == 4'h0 |->
        o_safety_cycles == CYC_PER_MS * DUR_SHORT_MS)
        else $error("short safety duration wrong");
    safety_step_a: assert property (o_safety_code inside {[4'h1:4'hE]} |->
        o_safety_cycles == o_safety_code * DUR_STEP_MS * CYC_PER_MS)
        else $error("stepped safety duration wrong");
    safety_long_a: assert property (o_safety_code == 4'hF |->
        o_safety_cycles == CYC_PER_MS * DUR_LONG_MS)
        else $error("long safety duration wrong");
    power_on_a: assert property ($rose(i_rst_b) |-> o_mode == MODE_SHUTDOWN &&
        !o_fb_350mv && !o_ilim_1p7a && !o_ovp_high && !o_volt_out_en)
        else $error("power-on settings wrong");
    settings_hold_a: assert property (!$stable({o_mode, o_volt_out_en, o_fb_350mv,
        o_ilim_1p7a, o_ovp_high, o_torch_code, o_flash_code, o_safety_code}) |-> !i_scl)
        else $error("setting changed without bus write");
    sda_change_a: assert property (!$stable(o_sda_oe) |-> !i_scl)
        else $error("data pin changed while clock high");
    ack_stands_a: assert property ($rose(o_sda_oe) |-> o_sda_oe [*8])
        else $error("data pin pull too short");

    cover property (o_mode == MODE_FLASH && o_volt_out_en);
    cover property (o_safety_code == 4'hF);
    cover property ($rose(o_sda_oe));
endmodule

bind fldr_regs fldr_regs_monitor u_mon (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_scl(i_scl),
    .i_sda(i_sda), .o_sda_oe(o_sda_oe), .o_mode(o_mode), .o_sinks_on(o_sinks_on),
    .o_volt_out_en(o_volt_out_en), .o_fb_350mv(o_fb_350mv), .o_ilim_1p7a(o_ilim_1p7a),
    .o_ovp_high(o_ovp_high), .o_torch_code(o_torch_code), .o_flash_code(o_flash_code),
    .o_safety_code(o_safety_code), .o_safety_cycles(o_safety_cycles));

// >>> verif/fldr_host.sv
/*
 Serial bus host model: drives SCL and pulls SDA low through an enable.
 Assumes the bench resolves SDA with a pull-up from both enables.
*/
`timescale 1ns/10ps
module fldr_host
    import fldr_pkg::*;
(
    input  wire logic i_mclk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_oe
);
    initial
    begin
        o_scl    = 1'b1;
        o_sda_oe = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask

    // Start or repeated start; leaves SCL low
    task automatic start();
        o_sda_oe = 1'b0;
        tick(8);
        o_scl = 1'b1;
        tick(8);
        o_sda_oe = 1'b1;
        tick(8);
        o_scl = 1'b0;
        tick(2);
    endtask

    task automatic stop();
        o_sda_oe = 1'b1;
        tick(8);
        o_scl = 1'b1;
        tick(8);
        o_sda_oe = 1'b0;
        tick(8);
    endtask

    // Data set while SCL low, sampled at the end of the high phase
    task automatic xbit(input logic b, output logic r);
        o_sda_oe = ~b;
        tick(8);
        o_scl = 1'b1;
        tick(8);
        r = i_sda;
        o_scl = 1'b0;
        tick(2);
    endtask

    task automatic xbyte(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--)
            xbit(d[i], q[i]);
        xbit(1'b1, a);
        ack = ~a;
    endtask

    task automatic wr(input logic [6:0] adr, input logic [7:0] p, input logic [7:0] d,
                      output logic ok);
        logic [7:0] q;
        logic       a0, a1, a2;
        start();
        xbyte({adr, 1'b0}, q, a0);
        xbyte(p, q, a1);
        xbyte(d, q, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask

    // Single-byte read ended by a not-acknowledge
    task automatic rd(input logic [7:0] p, output logic [7:0] d);
        logic [7:0] q;
        logic       a;
        start();
        xbyte({SLAVE_ADDR, 1'b0}, q, a);
        xbyte(p, q, a);
        start();
        xbyte({SLAVE_ADDR, 1'b1}, q, a);
        xbyte(8'hFF, d, a);
        stop();
    endtask
endmodule

// >>> verif/tb_top.sv
/*
 Self-checking bench for the flash LED register bank.
 Assumes the host model drives the serial pins and SDA has a pull-up.
*/
`timescale 1ns/10ps
module tb_top;
    import fldr_pkg::*;
    logic        mclk, rst_b, h_scl, h_oe, d_oe, volt, fb, ilim, overvolt_level_select, sinks, ok;
    wire  logic  sda = ~(h_oe | d_oe);
    fldr_mode_t  mode;
    logic [4:0]  torch;
    logic [6:0]  flash;
    logic [3:0]  scode;
    logic [31:0] scyc;
    logic [7:0]  q;
    int          err_total = 0;
    int          checks = 0;
    localparam logic [7:0] OFS [6] = '{OFS_GENERAL, OFS_MF_OPTIONS, OFS_STEP_TIME,
                                       OFS_TORCH, OFS_FLASH, OFS_SAFETY};
    localparam logic [7:0] RSTV [6] = '{RST_GENERAL, RST_MF_OPTIONS, RST_STEP_TIME,
                                        RST_TORCH, RST_FLASH, RST_SAFETY};

    fldr_host host (.i_mclk(mclk), .i_sda(sda), .o_scl(h_scl), .o_sda_oe(h_oe));
    fldr_regs dut (.i_mclk(mclk), .i_rst_b(rst_b), .i_scl(h_scl), .i_sda(sda),
        .o_sda_oe(d_oe), .o_mode(mode), .o_sinks_on(sinks), .o_volt_out_en(volt),
        .o_fb_350mv(fb), .o_ilim_1p7a(ilim), .o_ovp_high(overvolt_level_select), .o_torch_code(torch),
        .o_flash_code(flash), .o_safety_code(scode), .o_safety_cycles(scyc));

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s exp %0h got %0h", nm, exp, got);
        end
    endtask

    task automatic stop_test();
        if (err_total == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic t_power();
        chk("opts", 32'({mode, volt, fb, ilim, overvolt_level_select}), 32'h0);
        for (int i = 0; i < 6; i++)
        begin
            host.rd(OFS[i], q);
            chk("reset_rd", 32'(q), 32'(RSTV[i]));
        end
    endtask

    task automatic t_safety();
        int e;
        for (int c = 0; c < 16; c++)
        begin
            host.wr(SLAVE_ADDR, OFS_SAFETY, {4'h5, 4'(c)}, ok);
            e = c == 0 ? CYC_PER_MS * DUR_SHORT_MS : c * DUR_STEP_MS * CYC_PER_MS;
            e = c == 15 ? CYC_PER_MS * DUR_LONG_MS : e;
            chk("sfy_code", 32'(scode), 32'(c));
            chk("sfy_cyc", scyc, 32'(e));
            host.rd(OFS_SAFETY, q);
            chk("sfy_rd", 32'(q), 32'({4'hF, 4'(c)}));
        end
    endtask

    task automatic t_mode();
        logic [2:0] v;
        for (int i = 0; i < 8; i++)
        begin
            v = 3'(i);
            // Feedback bit opposite to voltage bit so a swapped pair shows up
            host.wr(SLAVE_ADDR, OFS_GENERAL, {2'b11, ~v[2], 2'b00, v}, ok);
            chk("gen_ack", 32'(ok), 32'h1);
            chk("mode", 32'(mode), 32'(v[1:0]));
            chk("sinks", 32'(sinks), 32'(v[1:0] != 2'b00));
            chk("volt_fb", 32'({volt, fb}), 32'({v[2], ~v[2]}));
            host.rd(OFS_GENERAL, q);
            chk("gen_rd", 32'(q), 32'({2'b00, ~v[2], 2'b11, v}));
        end
    endtask

    task automatic t_opts();
        host.wr(SLAVE_ADDR, OFS_MF_OPTIONS, 8'h10, ok);
        chk("ilim_only", 32'({ilim, overvolt_level_select}), 32'h2);
        host.wr(SLAVE_ADDR, OFS_MF_OPTIONS, 8'h18, ok);
        chk("ilim_ovp", 32'({ilim, overvolt_level_select}), 32'h3);
        host.rd(OFS_MF_OPTIONS, q);
        chk("mf_rd", 32'(q), 32'hF8);
        host.wr(SLAVE_ADDR, OFS_TORCH, 8'hFF, ok);
        host.wr(SLAVE_ADDR, OFS_FLASH, 8'hFF, ok);
        chk("codes", 32'({torch, flash}), 32'hFFF);
        host.rd(OFS_TORCH, q);
        chk("torch_rd", 32'(q), 32'h9F);
        host.rd(OFS_FLASH, q);
        chk("flash_rd", 32'(q), 32'hFF);
    endtask

    task automatic t_refuse();
        host.wr(7'h52, OFS_TORCH, 8'h00, ok);
        chk("bad_adr", 32'({ok, torch}), 32'h1F);
        host.wr(SLAVE_ADDR, 8'h30, 8'h00, ok);
        chk("unmap_ack", 32'(ok), 32'h1);
        host.rd(8'h30, q);
        chk("unmap_rd", 32'(q), 32'h0);
        repeat (2000) @(posedge mclk);
        chk("held", 32'({mode, volt, fb, ilim, overvolt_level_select, torch, flash}), 32'h3BFFF);
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    initial
    begin
        rst_b = 1'b0;
        repeat (6) @(posedge mclk);
        #1 rst_b = 1'b1;
        repeat (3) @(posedge mclk);
        t_power();
        t_safety();
        t_mode();
        t_opts();
        t_refuse();
        stop_test();
    end

    initial
    begin
        repeat (80000) @(posedge mclk);
        err_total++;
        stop_test();
    end
endmodule
